// >>> design/cfg_loader_pkg.sv
// package: constants, states and carriers for the master serial config loader
// assumes a 100 MHz system clock and a synchronous active-low reset
`default_nettype none
package cfg_loader_pkg;
    // =====================================================================
    // timing
    localparam int SYS_CLK_MHZ        = 100;
    localparam int PROG_MIN_NS        = 300;
    localparam int PROG_MIN_CYC       = (PROG_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CLEAR_CYC          = 64;
    localparam int DIV_SLOW           = 16;
    localparam int DIV_FAST           = 4;
    // =====================================================================
    // stream layout
    localparam logic [15:0] SYNC_WORD = 16'hA5C3;
    localparam int HDR_BITS           = 16;
    localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
    localparam int CRC_W              = 16;
    localparam logic [15:0] CRC_POLY  = 16'h8005;
    localparam logic [15:0] CRC_INIT  = 16'h0000;
    // =====================================================================
    // register map
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h1;
    localparam logic [3:0] REG_IRQ_ST  = 4'h2;
    localparam logic [3:0] REG_IRQ_MSK = 4'h3;
    localparam logic [3:0] REG_LENGTH  = 4'h4;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_CRC_BIT   = 1;
    localparam int IRQ_MODE_BIT  = 2;
    localparam int CTRL_FAST_BIT = 0;
    localparam logic [31:0] LENGTH_RST = 32'h0000_0100;

    typedef enum logic [5:0]
    {
        ST_CLEAR  = 6'h01,
        ST_WAIT   = 6'h02,
        ST_LOAD   = 6'h04,
        ST_CRC    = 6'h08,
        ST_DONE   = 6'h10,
        ST_ERROR  = 6'h20
    } cfg_state_e;

    typedef struct packed
    {
        logic rise;
        logic fall;
    } clk_edge_s;

    typedef struct packed
    {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;
endpackage
`default_nettype wire

// >>> design/cfg_sync2.sv
// two-flip-flop synchroniser for one level from outside the clock domain
// assumes the input is asynchronous to SYS_CLK
`default_nettype none
module cfg_sync2
    import cfg_loader_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // level
    input  wire logic d,
    output var  logic q
);
    logic meta_ff;
    logic q_ff;
    logic nxt_meta;
    logic nxt_q;

    always_comb
    begin
        nxt_meta = rst_n ? d : RST_VAL;
        nxt_q    = rst_n ? meta_ff : RST_VAL;
    end

    always_ff @(posedge clk)
    begin
        meta_ff <= nxt_meta;
        q_ff    <= nxt_q;
    end

    assign q = q_ff;
endmodule
`default_nettype wire

// >>> design/cfg_clk_gen.sv
// configuration clock generator: divides SYS_CLK, reports its own edges
// assumes run is held during loading; slow rate unless fast is set
`default_nettype none
module cfg_clk_gen
    import cfg_loader_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // control
    input  wire logic      run,
    input  wire logic      fast,
    // clock out and edge marks
    output var  logic      config_clock_out,
    output var  clk_edge_s edges
);
    logic [7:0] cnt_ff;
    logic       config_clock_out_ff;
    clk_edge_s  edges_ff;
    logic [7:0] nxt_cnt;
    logic       nxt_config_clock_out;
    clk_edge_s  nxt_edges;
    logic [7:0] half;

    always_comb
    begin
        half      = fast ? 8'(DIV_FAST / 2 - 1) : 8'(DIV_SLOW / 2 - 1);
        nxt_cnt   = cnt_ff;
        nxt_config_clock_out  = config_clock_out_ff;
        nxt_edges = '0;
        if (!rst_n || !run)
        begin
            nxt_cnt  = 8'h00;
            nxt_config_clock_out = 1'b0;
        end
        else if (cnt_ff >= half)
        begin
            nxt_cnt        = 8'h00;
            nxt_config_clock_out       = ~config_clock_out_ff;
            nxt_edges.rise = ~config_clock_out_ff;
            nxt_edges.fall = config_clock_out_ff;
        end
        else
        begin
            nxt_cnt = cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        cnt_ff   <= nxt_cnt;
        config_clock_out_ff  <= nxt_config_clock_out;
        edges_ff <= nxt_edges;
    end

    assign config_clock_out  = config_clock_out_ff;
    assign edges = edges_ff;
endmodule
`default_nettype wire

// >>> design/cfg_loader.sv
// master serial configuration loader: clears, waits on the init line,
// samples mode, clocks bits from the PROM, checks CRC, forwards the rest
// assumes open-drain lines are pulled up on the board
//
// Overview of operation
// - all mode bits low selects master serial
// - drive configuration clock from internal divider
// - capture one data bit per rising clock
// - release mode pins once done is high
// - pull-up select low enables user pull-ups; code turns them off again in ST_DONE
// - serial output driven throughout configuration
// - serial output feeds next chained device
// - init line low while memory clears
// - release init; sample mode on rise
// - wait while PROM holds init low
// - CRC error drives init low
// - done low until successful completion
// - program pulse over 300 ns restarts
// - start slow, speed up if data says
// - forward later data on falling edge
`default_nettype none
module cfg_loader
    import cfg_loader_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [31:0] REG_RDATA,
    output var  logic        IRQ,
    // configuration pins
    input  wire logic [2:0]  MODE_SEL_I,
    output var  logic        MODE_PINS_USER,
    input  wire logic        PULLUP_DISABLE_SELECT,
    output var  logic        USER_PULLUP_EN,
    input  wire logic        PROGRAM_REQUEST_N,
    output var  logic        CONFIG_CLOCK_OUT,
    input  wire logic        PROM_SERIAL_OUT,
    output var  logic        DOUT,
    output var  logic        DOUT_OE,
    // open-drain init and done lines
    input  wire logic        INIT_N_I,
    output var  logic        INIT_N_O,
    output var  logic        INIT_N_OE,
    input  wire logic        DONE_I,
    output var  logic        DONE_O,
    output var  logic        DONE_OE
);
    // =====================================================================
    // input synchronisers
    logic init_s;
    logic prog_s;
    logic pull_s;
    logic din_s;
    logic done_s;
    logic [2:0] mode_s;

    cfg_sync2 #(.RST_VAL(1'b1)) u_init (.clk(SYS_CLK), .rst_n(RST_N), .d(INIT_N_I),
        .q(init_s));
    cfg_sync2 #(.RST_VAL(1'b1)) u_prog (.clk(SYS_CLK), .rst_n(RST_N),
        .d(PROGRAM_REQUEST_N), .q(prog_s));
    cfg_sync2 #(.RST_VAL(1'b1)) u_pull (.clk(SYS_CLK), .rst_n(RST_N),
        .d(PULLUP_DISABLE_SELECT), .q(pull_s));
    cfg_sync2 #(.RST_VAL(1'b0)) u_din (.clk(SYS_CLK), .rst_n(RST_N),
        .d(PROM_SERIAL_OUT), .q(din_s));
    cfg_sync2 #(.RST_VAL(1'b0)) u_done (.clk(SYS_CLK), .rst_n(RST_N), .d(DONE_I),
        .q(done_s));

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_mode
            cfg_sync2 #(.RST_VAL(1'b1)) u_m (.clk(SYS_CLK), .rst_n(RST_N),
                .d(MODE_SEL_I[gi]), .q(mode_s[gi]));
        end
    endgenerate

    // =====================================================================
    // crc step
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    endfunction

    // =====================================================================
    // state
    cfg_state_e  state_ff;
    cfg_state_e  nxt_state;
    logic [7:0]  clr_cnt_ff;
    logic [7:0]  nxt_clr_cnt;
    logic [7:0]  prog_cnt_ff;
    logic [7:0]  nxt_prog_cnt;
    logic        prog_armed_ff;
    logic        nxt_prog_armed;
    logic [2:0]  mode_ff;
    logic [2:0]  nxt_mode;
    logic        fast_ff;
    logic        nxt_fast;
    logic [31:0] bit_cnt_ff;
    logic [31:0] nxt_bit_cnt;
    logic [15:0] shift_ff;
    logic [15:0] nxt_shift;
    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;
    logic        fwd_bit_ff;
    logic        nxt_fwd_bit;
    logic        dout_ff;
    logic        nxt_dout;
    logic        ev_done;
    logic        ev_crc;
    logic        ev_mode;
    logic        run;
    logic        config_clock_out;
    clk_edge_s   edges;
    logic [31:0] length_ff;
    logic        ctrl_fast_ff;

    assign run = (state_ff == ST_LOAD) || (state_ff == ST_CRC) || (state_ff == ST_DONE);

    cfg_clk_gen u_clk (.clk(SYS_CLK), .rst_n(RST_N), .run(run), .fast(fast_ff),
        .config_clock_out(config_clock_out), .edges(edges));

    always_comb
    begin
        nxt_state      = state_ff;
        nxt_clr_cnt    = clr_cnt_ff;
        nxt_prog_cnt   = prog_cnt_ff;
        nxt_prog_armed = prog_armed_ff;
        nxt_mode       = mode_ff;
        nxt_fast       = fast_ff;
        nxt_bit_cnt    = bit_cnt_ff;
        nxt_shift      = shift_ff;
        nxt_crc        = crc_ff;
        nxt_fwd_bit    = fwd_bit_ff;
        nxt_dout       = dout_ff;
        ev_done        = 1'b0;
        ev_crc         = 1'b0;
        ev_mode        = 1'b0;
        // program pulse width measure
        if (!prog_s)
        begin
            if (prog_cnt_ff != 8'(PROG_MIN_CYC - 1))
                nxt_prog_cnt = prog_cnt_ff + 8'h01;
            else
                nxt_prog_armed = 1'b1;
        end
        else
        begin
            nxt_prog_cnt = 8'h00;
        end
        case (state_ff)
            ST_CLEAR:
            begin
                nxt_fast = 1'b0;
                if (clr_cnt_ff == 8'(CLEAR_CYC - 1))
                    nxt_state = ST_WAIT;
                else
                    nxt_clr_cnt = clr_cnt_ff + 8'h01;
            end
            ST_WAIT:
            begin
                if (init_s && prog_s)
                begin
                    nxt_mode = mode_s;
                    if (mode_s == MODE_MASTER_SERIAL)
                    begin
                        nxt_state   = ST_LOAD;
                        nxt_bit_cnt = 32'h0;
                        nxt_crc     = CRC_INIT;
                    end
                    else
                    begin
                        nxt_state = ST_ERROR;
                        ev_mode   = 1'b1;
                    end
                end
            end
            ST_LOAD, ST_CRC:
            begin
                if (edges.rise)
                begin
                    nxt_shift   = {shift_ff[14:0], din_s};
                    nxt_bit_cnt = bit_cnt_ff + 32'h1;
                    if (state_ff == ST_LOAD)
                    begin
                        nxt_crc = crc_step(crc_ff, din_s);
                        if (bit_cnt_ff == 32'(HDR_BITS))
                            nxt_fast = ctrl_fast_ff | shift_ff[0];
                        if (bit_cnt_ff == length_ff - 32'h1)
                        begin
                            nxt_state   = ST_CRC;
                            nxt_bit_cnt = 32'h0;
                        end
                    end
                    else if (bit_cnt_ff == 32'(CRC_W - 1))
                    begin
                        if ({shift_ff[14:0], din_s} == crc_ff)
                        begin
                            nxt_state = ST_DONE;
                            ev_done   = 1'b1;
                        end
                        else
                        begin
                            nxt_state = ST_ERROR;
                            ev_crc    = 1'b1;
                        end
                    end
                end
            end
            ST_DONE:
            begin
                if (edges.rise)
                    nxt_fwd_bit = din_s;
                if (edges.fall)
                    nxt_dout = fwd_bit_ff;
            end
            ST_ERROR:
            begin
            end
            default:
            begin
                nxt_state = ST_CLEAR;
            end
        endcase
        // restart on release after a long enough pulse
        if (prog_armed_ff && prog_s)
        begin
            nxt_state      = ST_CLEAR;
            nxt_clr_cnt    = 8'h00;
            nxt_prog_armed = 1'b0;
        end
        if (!prog_s)
            nxt_state = ST_CLEAR;
        if (!RST_N)
        begin
            nxt_state      = ST_CLEAR;
            nxt_clr_cnt    = 8'h00;
            nxt_prog_cnt   = 8'h00;
            nxt_prog_armed = 1'b0;
            nxt_mode       = 3'h7;
            nxt_fast       = 1'b0;
            nxt_bit_cnt    = 32'h0;
            nxt_shift      = 16'h0000;
            nxt_crc        = CRC_INIT;
            nxt_fwd_bit    = 1'b0;
            nxt_dout       = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        state_ff      <= nxt_state;
        clr_cnt_ff    <= nxt_clr_cnt;
        prog_cnt_ff   <= nxt_prog_cnt;
        prog_armed_ff <= nxt_prog_armed;
        mode_ff       <= nxt_mode;
        fast_ff       <= nxt_fast;
        bit_cnt_ff    <= nxt_bit_cnt;
        shift_ff      <= nxt_shift;
        crc_ff        <= nxt_crc;
        fwd_bit_ff    <= nxt_fwd_bit;
        dout_ff       <= nxt_dout;
    end

    // =====================================================================
    // pin outputs
    logic config_clock_out_o_ff;
    logic dout_o_ff;
    logic dout_oe_ff;
    logic init_oe_ff;
    logic done_oe_ff;
    logic user_ff;
    logic pull_en_ff;
    logic nxt_config_clock_out_o;
    logic nxt_dout_o;
    logic nxt_dout_oe;
    logic nxt_init_oe;
    logic nxt_done_oe;
    logic nxt_user;
    logic nxt_pull_en;

    always_comb
    begin
        nxt_config_clock_out_o  = config_clock_out;
        nxt_dout_o  = dout_ff;
        nxt_dout_oe = 1'b1;
        nxt_init_oe = (state_ff == ST_CLEAR) || (state_ff == ST_ERROR);
        nxt_done_oe = (state_ff != ST_DONE);
        nxt_user    = (state_ff == ST_DONE) && done_s;
        nxt_pull_en = !pull_s && (state_ff != ST_DONE);
        if (!RST_N)
        begin
            nxt_config_clock_out_o  = 1'b0;
            nxt_dout_o  = 1'b0;
            nxt_init_oe = 1'b1;
            nxt_done_oe = 1'b1;
            nxt_user    = 1'b0;
            nxt_pull_en = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        config_clock_out_o_ff  <= nxt_config_clock_out_o;
        dout_o_ff  <= nxt_dout_o;
        dout_oe_ff <= nxt_dout_oe;
        init_oe_ff <= nxt_init_oe;
        done_oe_ff <= nxt_done_oe;
        user_ff    <= nxt_user;
        pull_en_ff <= nxt_pull_en;
    end

    // =====================================================================
    // registers and interrupt
    logic [2:0]  irq_st_ff;
    logic [2:0]  irq_msk_ff;
    logic [31:0] rdata_ff;
    logic        irq_ff;
    logic [2:0]  nxt_irq_st;
    logic [2:0]  nxt_irq_msk;
    logic [31:0] nxt_rdata;
    logic        nxt_irq;
    logic [31:0] nxt_length;
    logic        nxt_ctrl_fast;
    logic [2:0]  ev_vec;

    always_comb
    begin
        ev_vec        = '0;
        ev_vec[IRQ_DONE_BIT] = ev_done;
        ev_vec[IRQ_CRC_BIT]  = ev_crc;
        ev_vec[IRQ_MODE_BIT] = ev_mode;
        nxt_irq_st    = irq_st_ff;
        nxt_irq_msk   = irq_msk_ff;
        nxt_length    = length_ff;
        nxt_ctrl_fast = ctrl_fast_ff;
        nxt_rdata     = 32'h0;
        if (REG_WR)
        begin
            case (REG_ADDR)
                REG_CTRL:    nxt_ctrl_fast = REG_WDATA[CTRL_FAST_BIT];
                REG_IRQ_ST:  nxt_irq_st = irq_st_ff & ~REG_WDATA[2:0];
                REG_IRQ_MSK: nxt_irq_msk = REG_WDATA[2:0];
                REG_LENGTH:  nxt_length = REG_WDATA;
                default:     nxt_rdata = 32'h0;
            endcase
        end
        nxt_irq_st = nxt_irq_st | ev_vec;
        if (REG_RD)
        begin
            case (REG_ADDR)
                REG_CTRL:    nxt_rdata = {31'h0, ctrl_fast_ff};
                REG_STATUS:  nxt_rdata = {20'h0, mode_ff, fast_ff, 2'h0, state_ff};
                REG_IRQ_ST:  nxt_rdata = {29'h0, irq_st_ff};
                REG_IRQ_MSK: nxt_rdata = {29'h0, irq_msk_ff};
                REG_LENGTH:  nxt_rdata = length_ff;
                default:     nxt_rdata = 32'h0;
            endcase
        end
        nxt_irq = |(nxt_irq_st & irq_msk_ff);
        if (!RST_N)
        begin
            nxt_irq_st    = 3'h0;
            nxt_irq_msk   = 3'h0;
            nxt_length    = LENGTH_RST;
            nxt_ctrl_fast = 1'b0;
            nxt_rdata     = 32'h0;
            nxt_irq       = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        irq_st_ff    <= nxt_irq_st;
        irq_msk_ff   <= nxt_irq_msk;
        length_ff    <= nxt_length;
        ctrl_fast_ff <= nxt_ctrl_fast;
        rdata_ff     <= nxt_rdata;
        irq_ff       <= nxt_irq;
    end

    assign REG_RDATA        = rdata_ff;
    assign IRQ              = irq_ff;
    assign CONFIG_CLOCK_OUT = config_clock_out_o_ff;
    assign DOUT             = dout_o_ff;
    assign DOUT_OE          = dout_oe_ff;
    assign INIT_N_O         = 1'b0;
    assign INIT_N_OE        = init_oe_ff;
    assign DONE_O           = 1'b0;
    assign DONE_OE          = done_oe_ff;
    assign MODE_PINS_USER   = user_ff;
    assign USER_PULLUP_EN   = pull_en_ff;
endmodule
`default_nettype wire

// >>> verification/cfg_loader_monitor.sv
// checker: port-level properties of the configuration loader
// assumes a bind onto cfg_loader; one clock domain, sync active-low reset
`default_nettype none
module cfg_loader_monitor
    import cfg_loader_pkg::*;
(
    // clock and reset
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    // register port
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    // configuration pins
    input wire logic        MODE_PINS_USER,
    input wire logic        PULLUP_DISABLE_SELECT,
    input wire logic        USER_PULLUP_EN,
    input wire logic        PROGRAM_REQUEST_N,
    input wire logic        CONFIG_CLOCK_OUT,
    input wire logic        DOUT_OE,
    input wire logic        INIT_N_I,
    input wire logic        INIT_N_OE,
    input wire logic        DONE_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // =====================================================================
    // helper: no clock edge seen yet in this attempt
    logic first_ff;
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N || INIT_N_OE)
            first_ff <= 1'b1;
        else if (CONFIG_CLOCK_OUT)
            first_ff <= 1'b0;
    end
    // =====================================================================
    // properties
    reset_quiet_a: assert property ($rose(RST_N) |-> (INIT_N_OE && !CONFIG_CLOCK_OUT)[*8])
        else $error("init not held or clock running after reset");
    mode_release_a: assert property ($fell(DONE_OE) |-> ##[0:3] MODE_PINS_USER)
        else $error("mode pins not released after done");
    pullup_on_a: assert property ((DONE_OE && !PULLUP_DISABLE_SELECT)[*6] |-> USER_PULLUP_EN)
        else $error("pull-ups off with select low");
    pullup_off_a: assert property (PULLUP_DISABLE_SELECT[*6] |-> !USER_PULLUP_EN)
        else $error("pull-ups on with select high");
    dout_drive_a: assert property (DOUT_OE)
        else $error("serial output not driven");
    slow_start_a: assert property ($rose(CONFIG_CLOCK_OUT) && first_ff |->
        CONFIG_CLOCK_OUT[*8] ##1 !CONFIG_CLOCK_OUT)
        else $error("first clock phase not at slow rate");
    init_wait_a: assert property ((!INIT_N_I)[*3] |-> ##1 !$rose(CONFIG_CLOCK_OUT))
        else $error("clock started while init line low");
    done_excl_a: assert property (!DONE_OE |-> !INIT_N_OE)
        else $error("done and error flagged together");
    restart_clear_a: assert property ((!PROGRAM_REQUEST_N)[*3] |->
        ##[0:3] (DONE_OE && INIT_N_OE))
        else $error("program pulse did not restart");
    rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data outside read cycle");
    done_c: cover property ($fell(DONE_OE));
    error_c: cover property ($rose(INIT_N_OE) && DONE_OE);
    fast_c: cover property ($rose(CONFIG_CLOCK_OUT) ##2 $fell(CONFIG_CLOCK_OUT));
endmodule
bind cfg_loader cfg_loader_monitor u_mon (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .MODE_PINS_USER(MODE_PINS_USER),
    .PULLUP_DISABLE_SELECT(PULLUP_DISABLE_SELECT), .USER_PULLUP_EN(USER_PULLUP_EN),
    .PROGRAM_REQUEST_N(PROGRAM_REQUEST_N), .CONFIG_CLOCK_OUT(CONFIG_CLOCK_OUT),
    .DOUT_OE(DOUT_OE), .INIT_N_I(INIT_N_I), .INIT_N_OE(INIT_N_OE), .DONE_OE(DONE_OE));
`default_nettype wire

// >>> verification/prom_model.sv
// serial PROM model: header, payload, CRC, shifted out on the clock
// assumes chip enable from the done line, reset/enable from the init line
`default_nettype none
module prom_model
    import cfg_loader_pkg::*;
#(
    parameter int POR_NS = 2000
)
(
    // link
    input  wire logic config_clock_out,
    input  wire logic init_line,
    input  wire logic done_line,
    input  wire logic bad_crc,
    output var  logic data,
    output var  logic init_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    // crc covers header and payload, as the loader counts them together
    localparam logic [47:0] BODY = {SYNC_WORD, 32'h3C5A_0F96};
    logic [63:0] image;
    logic [15:0] crc;
    logic        fb;
    int          addr;
    always_comb
    begin
        crc = CRC_INIT;
        for (int i = 47; i >= 0; i--)
        begin
            fb = crc[15] ^ BODY[i];
            crc = {crc[14:0], 1'b0};
            if (fb)
                crc = crc ^ CRC_POLY;
        end
        image = {BODY, crc ^ {15'h0, bad_crc}};
    end
    // power-on hold of the init line
    initial
    begin
        addr = 0;
        data = 1'b0;
        init_pull = 1'b1;
        #POR_NS init_pull = 1'b0;
    end
    always @(negedge init_line) addr = 0;
    always @(posedge config_clock_out) #2 addr = addr + 1;
    // released line toggles so a stale bit never looks valid
    always @(addr, init_line, done_line)
        data = (init_line && !done_line && addr < 64) ? image[63-addr] : ~data;
endmodule
`default_nettype wire

// >>> verification/master_serial_config_loader_test.sv
// testbench: loads good and bad-CRC streams from the PROM model, then tries a bad mode that loads nothing
// assumes the register map and timing of cfg_loader_pkg
`default_nettype none
module master_serial_config_loader_test
    import cfg_loader_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, mode_user, pu_sel = 1'b0;
    logic pu_en, prog_n = 1'b1, config_clock_out, prom_d, dout, dout_oe, init_o, init_oe, done_o, done_oe;
    logic init_line, done_line, init_pull, bad_crc = 1'b0, d0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [2:0]  mode_sel = 3'h0;
    int num_errors = 0, checks = 0;
    always #5 sys_clk = ~sys_clk;
    assign init_line = (init_oe ? init_o : 1'b1) & ~init_pull;
    assign done_line = done_oe ? done_o : 1'b1;
    cfg_loader u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .IRQ(irq), .MODE_SEL_I(mode_sel), .MODE_PINS_USER(mode_user),
        .PULLUP_DISABLE_SELECT(pu_sel), .USER_PULLUP_EN(pu_en), .PROGRAM_REQUEST_N(prog_n),
        .CONFIG_CLOCK_OUT(config_clock_out), .PROM_SERIAL_OUT(prom_d), .DOUT(dout), .DOUT_OE(dout_oe),
        .INIT_N_I(init_line), .INIT_N_O(init_o), .INIT_N_OE(init_oe), .DONE_I(done_line),
        .DONE_O(done_o), .DONE_OE(done_oe));
    prom_model u_prom (.config_clock_out(config_clock_out), .init_line(init_line), .done_line(done_line),
        .bad_crc(bad_crc), .data(prom_d), .init_pull(init_pull));
    // =====================================================================
    // tasks
    task automatic give_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_check(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp,
                             input string what);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(what, exp, reg_rdata & m);
    endtask
    // sel 0: done released, 1: clock high, 2: init pulled by device
    task automatic wait_on(input int sel, input int lim);
        int n;
        n = 0;
        while (!(sel == 0 ? done_oe === 1'b0 : sel == 1 ? config_clock_out === 1'b1 : init_oe === 1'b1)
               && n < lim)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= lim)
        begin
            num_errors++;
            $display("ERROR wait %0d expected event seen timeout", sel);
            give_verdict();
        end
        #1;
    endtask
    task automatic program_pulse();
        @(posedge sys_clk);
        prog_n <= 1'b0;
        repeat (40) @(posedge sys_clk);
        prog_n <= 1'b1;
    endtask
    // =====================================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 check("init_oe", 1, init_oe);
        check("done_oe", 1, done_oe);
        check("dout_oe", 1, dout_oe);
        reg_check(REG_LENGTH, 32'hFFFF_FFFF, LENGTH_RST, "length reset");
        reg_check(4'hF, 32'hFFFF_FFFF, 32'h0, "unmapped");
        reg_write(REG_LENGTH, 32'h0000_0030);
        reg_write(REG_IRQ_MSK, 32'h0000_0007);
        reg_check(REG_LENGTH, 32'hFFFF_FFFF, 32'h0000_0030, "length");
        repeat (80) @(posedge sys_clk);
        reg_check(REG_STATUS, 32'h0000_003F, {26'h0, ST_WAIT}, "held state");
        check("config_clock_out held", 0, config_clock_out);
        wait_on(1, 500);
        check("pullup on", 1, pu_en);
        mode_sel <= 3'h5;
        wait_on(0, 3000);
        repeat (4) @(posedge sys_clk);
        #1 check("mode user", 1, mode_user);
        check("pullup done", 0, pu_en);
        check("init released", 0, init_oe);
        check("irq done", 1, irq);
        // released prom toggles its bit each clock; forwarded copy must follow
        d0 = dout;
        repeat (4) @(posedge sys_clk);
        #1 check("dout fwd", !d0, dout);
        reg_check(REG_IRQ_ST, 32'h0000_0007, 32'h1, "irq status");
        reg_check(REG_STATUS, 32'h0000_0F00, 32'h0000_0100, "fast, mode");
        reg_write(REG_IRQ_ST, 32'h0000_0007);
        reg_write(REG_IRQ_MSK, 32'h0);
        repeat (2) @(posedge sys_clk);
        #1 check("irq cleared", 0, irq);
        mode_sel <= 3'h0;
        pu_sel <= 1'b1;
        bad_crc <= 1'b1;
        program_pulse();
        #1 check("done restart", 1, done_oe);
        wait_on(1, 500);
        check("pullup off", 0, pu_en);
        wait_on(2, 3000);
        check("done on crc", 1, done_oe);
        check("irq masked", 0, irq);
        reg_check(REG_IRQ_ST, 32'h0000_0007, 32'h2, "crc status");
        reg_write(REG_IRQ_MSK, 32'h0000_0002);
        repeat (2) @(posedge sys_clk);
        #1 check("irq unmasked", 1, irq);
        reg_write(REG_IRQ_ST, 32'h0000_0002);
        mode_sel <= 3'h3;
        bad_crc <= 1'b0;
        program_pulse();
        repeat (100) @(posedge sys_clk);
        #1 check("bad mode clock", 0, config_clock_out);
        check("bad mode init", 1, init_oe);
        reg_check(REG_IRQ_ST, 32'h0000_0007, 32'h4, "mode status");
        give_verdict();
    end
endmodule
`default_nettype wire
